/* File: logic/ircm_pkg.sv */
`default_nettype none
package ircm_pkg;
    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_RX_DEMOD = 3'h0;
    localparam logic [2:0] IDX_TX_MOD = 3'h1;
    localparam logic [2:0] IDX_RC_CFG = 3'h2;
    localparam logic [2:0] IDX_LC_BANK = 3'h3;
    localparam logic [2:0] IDX_CFG_ONE = 3'h4;
    localparam logic [2:0] IDX_RSVD = 3'h5;
    localparam logic [2:0] IDX_CFG_THREE = 3'h6;
    localparam logic [2:0] IDX_CFG_FOUR = 3'h7;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 4;

    localparam logic [7:0] RST_RX_DEMOD = 8'h29;
    localparam logic [7:0] RST_TX_MOD = 8'h69;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // value written at index 3 that opens this bank
    localparam logic [7:0] BANK_CODE = 8'hf4;

    // field positions
    localparam int CODE_MSB = 4;
    localparam int BW_LSB = 5;
    localparam int BW_MSB = 7;
    localparam int TX_HIGH_BIT = 2;
    localparam int RX_DEMOD_DIS_BIT = 4;
    localparam int RX_HIGH_BIT = 5;
    localparam int AUTO_CFG_BIT = 7;
    localparam int SEL0_OUT_BIT = 0;
    localparam int SEL21_OUT_BIT = 1;
    localparam int ID3_BIT = 3;

    // clock in units of 0.1 KHz; frequencies below are in the same unit
    localparam logic [16:0] CLK_DKHZ = 17'h186a0;
    localparam logic [12:0] LOW_BASE_DKHZ = 13'h10e;
    localparam logic [12:0] LOW_STEP_DKHZ = 13'h00a;
    localparam logic [12:0] LOW_TOP_DKHZ = 13'h239;
    localparam logic [12:0] HI_400_DKHZ = 13'hfa0;
    localparam logic [12:0] HI_450_DKHZ = 13'h1194;
    localparam logic [12:0] HI_480_DKHZ = 13'h12c0;
    localparam logic [12:0] FIXED_DKHZ = 13'h1388;
    localparam logic [4:0] CODE_LOW_FIRST = 5'h02;
    localparam logic [4:0] CODE_LOW_LAST = 5'h1d;
    localparam logic [4:0] CODE_LOW_TOP = 5'h1e;
    localparam logic [4:0] CODE_HI_400 = 5'h03;
    localparam logic [4:0] CODE_HI_450 = 5'h08;
    localparam logic [4:0] CODE_HI_480 = 5'h0b;
    // tolerance per bandwidth step as a divisor of the period
    localparam logic [4:0] BW_DIV = 5'h14;

    // pulse widths in 0.1 us, which is one clock at 10 MHz
    localparam logic [9:0] PW_LOW_6US = 10'h03c;
    localparam logic [9:0] PW_LOW_7US = 10'h046;
    localparam logic [9:0] PW_LOW_9US = 10'h05a;
    localparam logic [9:0] PW_LOW_10US6 = 10'h06a;
    localparam logic [9:0] PW_HI_0US7 = 10'h007;
    localparam logic [9:0] PW_HI_0US8 = 10'h008;
    localparam logic [9:0] PW_HI_0US9 = 10'h009;
    localparam logic [9:0] CNT_MAX = 10'h3ff;

    typedef enum logic [1:0] {
        IRCM_UART = 2'b00,
        IRCM_FIXED = 2'b01,
        IRCM_REMOTE = 2'b10,
        IRCM_OTHER = 2'b11
    } ircm_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } ircm_apb_req_t;
endpackage
`default_nettype wire

/* File: logic/ircm_top.sv */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ircm_top (
    input wire logic clk,
    input wire logic rst,
    input wire ircm_pkg::ircm_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ircm_pkg::ircm_mode_t ir_mode,
    input wire logic fixed_demod_dis,
    input wire logic tx_carrier_req,
    input wire logic ir_rx_pin,
    input wire logic id3_pin,
    input wire logic [2:0] transceiver_mode_select_pins_in,
    output logic [2:0] transceiver_mode_select_pins_out,
    output logic [2:0] transceiver_mode_select_pins_oe,
    output logic ir_tx_out,
    output logic rx_envelope
);
    import ircm_pkg::*;

    function automatic logic [9:0] period_of(input logic [12:0] f_dkhz);
        logic [16:0] q;
        q = (f_dkhz == 13'h0000) ? 17'h00000 : CLK_DKHZ / {4'h0, f_dkhz};
        period_of = q[9:0];
    endfunction

    function automatic logic [12:0] low_freq(input logic [4:0] code);
        logic [12:0] f;
        f = 13'h0000;
        if (code == CODE_LOW_TOP)
            f = LOW_TOP_DKHZ;
        else if (code >= CODE_LOW_FIRST && code <= CODE_LOW_LAST)
            f = LOW_BASE_DKHZ + {8'h00, code} * LOW_STEP_DKHZ;
        low_freq = f;
    endfunction

    function automatic logic [12:0] high_freq(input logic [4:0] code);
        logic [12:0] f;
        f = 13'h0000;
        case (code)
            CODE_HI_400: f = HI_400_DKHZ;
            CODE_HI_450: f = HI_450_DKHZ;
            CODE_HI_480: f = HI_480_DKHZ;
            default: f = 13'h0000;
        endcase
        high_freq = f;
    endfunction

    logic [7:0] rx_demod_ff;
    logic [7:0] tx_mod_ff;
    logic [7:0] rc_cfg_ff;
    logic [7:0] lc_bank_ff;
    logic [7:0] cfg_one_ff;
    logic [7:0] cfg_three_ff;
    logic [7:0] cfg_four_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    logic [2:0] sel_s1_ff;
    logic [2:0] sel_s2_ff;
    logic id3_s1_ff;
    logic id3_s2_ff;
    logic rx_s1_ff;
    logic rx_s2_ff;
    logic rx_prev_ff;

    logic [9:0] rx_cnt_ff;
    logic rx_ok_ff;
    logic rx_env_ff;
    logic [9:0] tx_cnt_ff;
    logic tx_out_ff;
    logic [2:0] sel_out_ff;
    logic [2:0] sel_oe_ff;

    logic [2:0] idx;
    logic addr_ok;
    logic bank_open;
    logic access;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic [7:0] cfg_one_rd;

    assign idx = apb_req.paddr[ADDR_MSB:ADDR_LSB];
    assign addr_ok = (apb_req.paddr[31:ADDR_MSB+1] == '0) && (apb_req.paddr[ADDR_LSB-1:0] == '0);
    assign bank_open = (lc_bank_ff == BANK_CODE);
    assign access = apb_req.psel && apb_req.penable && pready_ff;
    assign wr_en = access && apb_req.pwrite && addr_ok;
    assign wbyte = apb_req.pwdata[7:0];

    // bus handshake: one wait state, answer registered
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pready_ff <= 1'b0;
        else
            pready_ff <= apb_req.psel && apb_req.penable && !pready_ff;
    end

    // pin levels replace written bits while a pin is an input
    always_comb
    begin
        cfg_one_rd = cfg_one_ff;
        if (!cfg_four_ff[SEL0_OUT_BIT])
            cfg_one_rd[0] = sel_s2_ff[0];
        if (!cfg_four_ff[SEL21_OUT_BIT])
            cfg_one_rd[2:1] = sel_s2_ff[2:1];
        cfg_one_rd[ID3_BIT] = id3_s2_ff;
    end

    always_comb
    begin
        rd_byte = 8'h00;
        if (idx == IDX_LC_BANK)
            rd_byte = lc_bank_ff;
        else if (!bank_open)
            rd_byte = 8'h00;
        else if (idx == IDX_RX_DEMOD)
            rd_byte = rx_demod_ff;
        else if (idx == IDX_TX_MOD)
            rd_byte = tx_mod_ff;
        else if (idx == IDX_RC_CFG)
            rd_byte = rc_cfg_ff;
        else if (idx == IDX_CFG_ONE)
            rd_byte = cfg_one_rd;
        else if (idx == IDX_CFG_THREE)
            rd_byte = cfg_three_ff;
        else if (idx == IDX_CFG_FOUR)
            rd_byte = cfg_four_ff;
        else
            rd_byte = 8'h00;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (apb_req.psel && apb_req.penable && !pready_ff)
        begin
            prdata_ff <= (addr_ok && !apb_req.pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
            pslverr_ff <= !addr_ok;
        end
        else
        begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end

    // index 3 is reachable from every bank, the rest only when this bank is open
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            lc_bank_ff <= RST_ZERO;
        else if (wr_en && idx == IDX_LC_BANK)
            lc_bank_ff <= wbyte;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_demod_ff <= RST_RX_DEMOD;
            tx_mod_ff <= RST_TX_MOD;
            rc_cfg_ff <= RST_ZERO;
            cfg_one_ff <= RST_ZERO;
            cfg_three_ff <= RST_ZERO;
            cfg_four_ff <= RST_ZERO;
        end
        else if (wr_en && bank_open)
        begin
            if (idx == IDX_RX_DEMOD)
                rx_demod_ff <= wbyte;
            else if (idx == IDX_TX_MOD)
                tx_mod_ff <= wbyte;
            else if (idx == IDX_RC_CFG)
                rc_cfg_ff <= wbyte;
            else if (idx == IDX_CFG_ONE)
                cfg_one_ff <= wbyte;
            else if (idx == IDX_CFG_THREE)
                cfg_three_ff <= wbyte;
            else if (idx == IDX_CFG_FOUR)
                cfg_four_ff <= wbyte;
        end
    end

    // pins are asynchronous to clk
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_s1_ff <= 3'h0;
            sel_s2_ff <= 3'h0;
            id3_s1_ff <= 1'b0;
            id3_s2_ff <= 1'b0;
            rx_s1_ff <= 1'b0;
            rx_s2_ff <= 1'b0;
            rx_prev_ff <= 1'b0;
        end
        else
        begin
            sel_s1_ff <= transceiver_mode_select_pins_in;
            sel_s2_ff <= sel_s1_ff;
            id3_s1_ff <= id3_pin;
            id3_s2_ff <= id3_s1_ff;
            rx_s1_ff <= ir_rx_pin;
            rx_s2_ff <= rx_s1_ff;
            rx_prev_ff <= rx_s2_ff;
        end
    end

    // receive demodulator: period between rising edges against a window
    logic rx_edge;
    logic rx_dis;
    logic [12:0] rx_f;
    logic [9:0] rx_p;
    logic [12:0] rx_tol_w;
    logic [9:0] rx_tol;
    logic in_window;

    assign rx_edge = rx_s2_ff && !rx_prev_ff;
    assign rx_dis = (ir_mode == IRCM_REMOTE) ? rc_cfg_ff[RX_DEMOD_DIS_BIT] : fixed_demod_dis;

    always_comb
    begin
        if (ir_mode == IRCM_FIXED)
            rx_f = FIXED_DKHZ;
        else if (rc_cfg_ff[RX_HIGH_BIT])
            rx_f = high_freq(rx_demod_ff[CODE_MSB:0]);
        else
            rx_f = low_freq(rx_demod_ff[CODE_MSB:0]);
        rx_p = period_of(rx_f);
        rx_tol_w = ({3'h0, rx_p} * {10'h000, rx_demod_ff[BW_MSB:BW_LSB]}) / {8'h00, BW_DIV};
        rx_tol = rx_tol_w[9:0];
        in_window = (rx_p != 10'h000) && (rx_cnt_ff + rx_tol >= rx_p) && (rx_cnt_ff <= rx_p + rx_tol);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rx_cnt_ff <= 10'h000;
        else if (rx_edge)
            rx_cnt_ff <= 10'h001;
        else if (rx_cnt_ff != CNT_MAX)
            rx_cnt_ff <= rx_cnt_ff + 10'h001;
    end

    // a stalled carrier saturates the counter and drops acceptance
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rx_ok_ff <= 1'b0;
        else if (rx_edge)
            rx_ok_ff <= in_window;
        else if (rx_cnt_ff == CNT_MAX)
            rx_ok_ff <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rx_env_ff <= 1'b0;
        else if (rx_dis)
            rx_env_ff <= rx_s2_ff;
        else
            rx_env_ff <= rx_ok_ff;
    end

    // transmit modulator
    logic [9:0] tx_p;
    logic [9:0] tx_pw;
    logic tx_high;

    always_comb
    begin
        tx_high = (ir_mode == IRCM_FIXED) || rc_cfg_ff[TX_HIGH_BIT];
        if (ir_mode == IRCM_FIXED)
            tx_p = period_of(FIXED_DKHZ);
        else if (rc_cfg_ff[TX_HIGH_BIT])
            tx_p = period_of(high_freq(tx_mod_ff[CODE_MSB:0]));
        else
            tx_p = period_of(low_freq(tx_mod_ff[CODE_MSB:0]));
        tx_pw = 10'h000;
        case (tx_mod_ff[BW_MSB:BW_LSB])
            3'h2: tx_pw = tx_high ? PW_HI_0US7 : PW_LOW_6US;
            3'h3: tx_pw = tx_high ? PW_HI_0US8 : PW_LOW_7US;
            3'h4: tx_pw = tx_high ? PW_HI_0US9 : PW_LOW_9US;
            3'h5: tx_pw = tx_high ? 10'h000 : PW_LOW_10US6;
            default: tx_pw = 10'h000;
        endcase
    end

    // reserved codes give a zero period and keep the carrier off
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tx_cnt_ff <= 10'h000;
        else if (!tx_carrier_req || tx_cnt_ff + 10'h001 >= tx_p)
            tx_cnt_ff <= 10'h000;
        else
            tx_cnt_ff <= tx_cnt_ff + 10'h001;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tx_out_ff <= 1'b0;
        else
            tx_out_ff <= tx_carrier_req && (tx_p != 10'h000) && (tx_cnt_ff < tx_pw) &&
                (ir_mode == IRCM_FIXED || ir_mode == IRCM_REMOTE);
    end

    // transceiver select pins
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_out_ff <= 3'h0;
            sel_oe_ff <= 3'h0;
        end
        else
        begin
            sel_oe_ff <= {{2{cfg_four_ff[SEL21_OUT_BIT]}}, cfg_four_ff[SEL0_OUT_BIT]};
            if (!cfg_four_ff[AUTO_CFG_BIT])
                sel_out_ff <= cfg_one_ff[2:0];
            else if (ir_mode == IRCM_UART)
                sel_out_ff <= 3'h0;
            else if (ir_mode == IRCM_FIXED)
                sel_out_ff <= cfg_one_ff[2:0];
            else
                sel_out_ff <= cfg_three_ff[2:0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign transceiver_mode_select_pins_out = sel_out_ff;
    assign transceiver_mode_select_pins_oe = sel_oe_ff;
    assign ir_tx_out = tx_out_ff;
    assign rx_envelope = rx_env_ff;
endmodule
`default_nettype wire

/* File: tb/ircm_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ircm_chk (
    input wire logic clk,
    input wire logic rst,
    input wire ircm_pkg::ircm_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ircm_pkg::ircm_mode_t ir_mode,
    input wire logic tx_carrier_req,
    input wire logic [2:0] transceiver_mode_select_pins_oe,
    input wire logic ir_tx_out
);
    import ircm_pkg::*;
    logic acc;
    logic fx;
    assign acc = apb_req.psel && apb_req.penable;
    assign fx = ir_tx_out && ir_mode == IRCM_FIXED;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_ready_after;
        acc && !pready |=> pready;
    endproperty
    a_ready_after: assert property (p_ready_after)
        else $error("no answer after access");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    property p_rdata_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside answer");
    property p_err_unmapped;
        pready && apb_req.paddr > 32'h1c |-> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("unmapped address not refused");
    property p_rsvd_zero;
        pready && !apb_req.pwrite && apb_req.paddr == 32'h14 |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved place not zero");
    property p_tx_idle;
        !tx_carrier_req |=> !ir_tx_out;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("carrier without request");
    property p_fixed_max;
        fx [*8] ##1 fx |=> !fx;
    endproperty
    a_fixed_max: assert property (p_fixed_max)
        else $error("fixed carrier pulse too long");
    property p_oe_change;
        $changed(transceiver_mode_select_pins_oe) |-> $past(pready && apb_req.pwrite, 2)
            || $past(pready && apb_req.pwrite, 3);
    endproperty
    a_oe_change: assert property (p_oe_change)
        else $error("pin direction changed without write");
endmodule
bind ircm_top ircm_chk chk_u (.clk(clk), .rst(rst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ir_mode(ir_mode), .tx_carrier_req(tx_carrier_req),
    .transceiver_mode_select_pins_oe(transceiver_mode_select_pins_oe), .ir_tx_out(ir_tx_out));
`default_nettype wire

/* File: tb/ircm_xcvr.sv */
`timescale 1ns/100ps
`default_nettype none
module ircm_xcvr (
    input wire logic clk,
    input wire logic [8:0] half,
    output logic rx_pin,
    output logic id3,
    output logic [2:0] id_bits
);
    // line stands low while half is zero
    initial
    begin
        rx_pin = 1'b0;
        id3 = 1'b1;
        id_bits = 3'b010;
        forever
        begin
            @(posedge clk);
            if (half == 9'h000)
                rx_pin <= 1'b0;
            else
            begin
                repeat (half - 9'h001) @(posedge clk);
                rx_pin <= ~rx_pin;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ircm_pkg::*;
    logic clk;
    logic rst;
    ircm_apb_req_t req;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ircm_mode_t mode;
    logic txreq;
    logic ddis;
    logic rxp;
    logic id3;
    logic [2:0] xid;
    logic [2:0] pout;
    logic [2:0] poe;
    logic [2:0] pins;
    logic txo;
    logic env;
    logic [8:0] half;
    logic [31:0] rdv;
    logic erv;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int hi;
    int per;

    assign pins = (poe & pout) | (~poe & xid);
    ircm_top dut_u (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ir_mode(mode), .fixed_demod_dis(ddis), .tx_carrier_req(txreq), .ir_rx_pin(rxp), .id3_pin(id3),
        .transceiver_mode_select_pins_in(pins), .transceiver_mode_select_pins_out(pout),
        .transceiver_mode_select_pins_oe(poe), .ir_tx_out(txo), .rx_envelope(env));
    ircm_xcvr xcvr_u (.clk(clk), .half(half), .rx_pin(rxp), .id3(id3), .id_bits(xid));

    task automatic end_sim();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1);
        rdv = prdata;
        erv = pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        xfer(1'b1, {27'h0, i, 2'b00}, d);
    endtask

    task automatic rd(input logic [2:0] i, input logic [7:0] e);
        xfer(1'b0, {27'h0, i, 2'b00}, 8'h00);
        chk(rdv, {24'h0, e});
    endtask

    // one full high and low phase of the carrier, counted in clocks
    task automatic txm();
        int n;
        n = 0;
        hi = 0;
        per = 0;
        while (txo === 1'b1 && n < 999) begin @(posedge clk); n++; end
        while (txo !== 1'b1 && n < 999) begin @(posedge clk); n++; end
        while (txo === 1'b1 && n < 999) begin @(posedge clk); n++; hi++; end
        while (txo !== 1'b1 && n < 999) begin @(posedge clk); n++; per++; end
        per = per + hi;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            $display("[ERR] t=%0t cyc=%h limit=%h", $time, cyc, 40000);
            end_sim();
        end
    end

    initial
    begin
        rst = 1'b1;
        req = '0;
        mode = IRCM_UART;
        txreq = 1'b0;
        ddis = 1'b0;
        half = 9'h000;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(IDX_RX_DEMOD, 8'h00);
        wr(IDX_LC_BANK, BANK_CODE);
        rd(IDX_LC_BANK, BANK_CODE);
        rd(IDX_RX_DEMOD, RST_RX_DEMOD);
        rd(IDX_TX_MOD, RST_TX_MOD);
        rd(IDX_CFG_ONE, 8'h0a);
        wr(IDX_RSVD, 8'hff);
        rd(IDX_RSVD, 8'h00);
        xfer(1'b0, 32'h20, 8'h00);
        chk({31'h0, erv}, 32'h1);
        mode <= IRCM_REMOTE;
        half <= 9'h08b;
        repeat (2000) @(posedge clk);
        chk({31'h0, env}, 32'h1);
        half <= 9'h06f;
        repeat (2000) @(posedge clk);
        chk({31'h0, env}, 32'h0);
        wr(IDX_RX_DEMOD, 8'h2b);
        wr(IDX_RC_CFG, 8'h20);
        half <= 9'h00a;
        repeat (2000) @(posedge clk);
        chk({31'h0, env}, 32'h1);
        txreq <= 1'b1;
        txm();
        chk(hi, 70);
        chk({31'h0, per >= 277 && per <= 279}, 32'h1);
        wr(IDX_TX_MOD, 8'h6b);
        wr(IDX_RC_CFG, 8'h04);
        txm();
        chk(hi, 8);
        chk({31'h0, per >= 20 && per <= 21}, 32'h1);
        mode <= IRCM_FIXED;
        wr(IDX_RX_DEMOD, RST_RX_DEMOD);
        repeat (2000) @(posedge clk);
        chk({31'h0, env}, 32'h1);
        // slow carrier is out of window, so only the raw path can show it high
        ddis <= 1'b1;
        half <= 9'h06f;
        repeat (600) @(posedge clk);
        wait (rxp === 1'b1);
        repeat (5) @(posedge clk);
        chk({31'h0, env}, 32'h1);
        ddis <= 1'b0;
        txm();
        chk(per, 20);
        wr(IDX_TX_MOD, 8'h8b);
        txm();
        chk(hi, 9);
        txreq <= 1'b0;
        mode <= IRCM_UART;
        wr(IDX_CFG_THREE, 8'h05);
        wr(IDX_CFG_FOUR, 8'h83);
        repeat (3) @(posedge clk);
        chk({29'h0, poe}, 32'h7);
        chk({29'h0, pout}, 32'h0);
        mode <= IRCM_REMOTE;
        repeat (3) @(posedge clk);
        chk({29'h0, pout}, 32'h5);
        rd(IDX_CFG_FOUR, 8'h83);
        for (int i = 0; i < 2; i++)
        begin
            wr(3'(i), 8'h5a);
            rd(3'(i), 8'h5a);
        end
        end_sim();
    end
endmodule
`default_nettype wire
